/* hw/tig_gap_timer.sv */
// Transmit inter-packet gap timer with its register slave.
// Assumes tx_end and tx_b2b come from transmit logic on clk_sys and
// carrier_in comes straight from the line-side pin.
// Software is expected to keep the two reserved top bits at zero.
`timescale 1ns/10ps

// Function
// - Low field sets back-to-back gap
// - Gaps count MAC clocks, speed dependent
// - Twisted pair adds four clocks overhead
// - Ten-bit interface adds ten, variant six
// - Carrier in first phase restarts count
// - After first phase carrier is ignored
// - Total field plus six clocks overhead
// - Phase fields used only in half-duplex
// - Top two bits read zero
module tig_gap_timer #(
  parameter bit TBI_ALT_OVERHEAD = 1'b0 // Variant that adds six in TBI
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [tig_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic tx_end,
  input wire logic tx_b2b,
  input wire logic carrier_in,
  output logic tx_allow
);

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [29:0] gap_reg; // Software gap fields
  logic [tig_pkg::CTRL_W-1:0] ctrl_reg; // Duplex, TBI, speed
  logic [31:0] rdata_reg;
  logic wait_reg;
  logic cs1_reg, cs2_reg, cs3_reg; // Carrier synchroniser
  logic cs_reg; // Debounced carrier level
  logic [tig_pkg::ACC_W-1:0] acc_reg; // Fractional ns accumulator
  logic tick_reg; // One MAC clock elapsed
  tig_pkg::tig_state_t state_reg, state_next;
  logic [tig_pkg::CNT_W-1:0] count_reg, count_next;
  logic [tig_pkg::CNT_W-1:0] target_reg, target_next;
  logic [tig_pkg::CNT_W-1:0] r1_reg, r1_next;
  logic allow_reg;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  wire logic sel_gap = avs_address == tig_pkg::ADDR_GAP_TIMING;
  wire logic sel_ctrl = avs_address == tig_pkg::ADDR_CONTROL;
  wire logic sel_stat = avs_address == tig_pkg::ADDR_STATUS;
  wire logic req = avs_read | avs_write;
  // Data phase: the cycle in which waitrequest is already low
  wire logic wr_take = avs_write & ~wait_reg;
  wire logic half = ctrl_reg[tig_pkg::CTRL_HALF_BIT];
  wire logic tbi = ctrl_reg[tig_pkg::CTRL_TBI_BIT];
  wire logic [1:0] speed = ctrl_reg[tig_pkg::CTRL_SPEED_LSB +: 2];
  wire logic [31:0] stat_word = {29'h0, cs_reg, state_reg == tig_pkg::TIG_PH1,
    state_reg != tig_pkg::TIG_IDLE};
  // Unmapped addresses read zero; the reserved top bits always do
  wire logic [31:0] rd_mux = sel_gap ? {2'h0, gap_reg} :
    sel_ctrl ? {28'h0, ctrl_reg} : sel_stat ? stat_word : 32'h0000_0000;

  // ------------------------------------------------------------
  // Register slave: one wait state on every access
  // ------------------------------------------------------------
  // A fixed single wait state keeps the read mux off the output path;
  // read data come from a flop, like every other output of this block.
  // Waitrequest drops for exactly one cycle after a request is seen
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wait_reg <= ~(req & wait_reg);
      if (avs_read & wait_reg) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  // Writes land on the edge where waitrequest is seen low
  // Reserved bits are never stored, so they cannot read back as ones
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      gap_reg <= tig_pkg::GAP_RESET;
      ctrl_reg <= tig_pkg::CTRL_RESET;
    end else begin
      if (wr_take & sel_gap) begin
        gap_reg <= avs_writedata[tig_pkg::GAP_USED_W-1:0];
      end
      if (wr_take & sel_ctrl) begin
        ctrl_reg <= avs_writedata[tig_pkg::CTRL_W-1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Carrier synchroniser
  // ------------------------------------------------------------
  // Level only moves once the second and third stages agree
  // A blip shorter than two cycles may be missed; real carrier bursts
  // last far longer, so nothing is lost in practice.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cs1_reg <= 1'b0;
      cs2_reg <= 1'b0;
      cs3_reg <= 1'b0;
      cs_reg <= 1'b0;
    end else begin
      cs1_reg <= carrier_in;
      cs2_reg <= cs1_reg;
      cs3_reg <= cs2_reg;
      if (cs2_reg == cs3_reg) begin
        cs_reg <= cs3_reg;
      end
    end
  end

  // ------------------------------------------------------------
  // MAC clock tick from a fractional ns accumulator
  // ------------------------------------------------------------
  // 8 ns is not a whole number of 5 ns cycles, so ticks jitter by one
  // cycle but their average rate is exact.
  wire logic [tig_pkg::ACC_W-1:0] mac_ns =
    (speed == tig_pkg::SPEED_1G) ? tig_pkg::ACC_W'(tig_pkg::MAC_PERIOD_1G_NS) :
    (speed == tig_pkg::SPEED_100M) ? tig_pkg::ACC_W'(tig_pkg::MAC_PERIOD_100M_NS) :
    tig_pkg::ACC_W'(tig_pkg::MAC_PERIOD_10M_NS);
  wire logic [tig_pkg::ACC_W-1:0] acc_sum = acc_reg + tig_pkg::ACC_W'(tig_pkg::CLK_PERIOD_NS);
  wire logic acc_wrap = acc_sum >= mac_ns;
  // After a speed change the old remainder may exceed the new period;
  // clearing it then avoids a burst of ticks on consecutive cycles
  wire logic [tig_pkg::ACC_W-1:0] acc_rem = acc_sum - mac_ns;
  wire logic [tig_pkg::ACC_W-1:0] acc_next = acc_wrap ? ((acc_rem >= mac_ns) ? '0 : acc_rem) : acc_sum;

  // Accumulator and tick pulse
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      acc_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      tick_reg <= acc_wrap;
    end
  end

  // ------------------------------------------------------------
  // Gap lengths
  // ------------------------------------------------------------
  // Fields are widened by one bit so that field plus overhead never wraps
  wire logic [tig_pkg::CNT_W-1:0] f_b2b = {1'b0, gap_reg[tig_pkg::B2B_LSB +: tig_pkg::FIELD_W]};
  wire logic [tig_pkg::CNT_W-1:0] f_first = {1'b0, gap_reg[tig_pkg::FIRST_LSB +: tig_pkg::FIELD_W]};
  wire logic [tig_pkg::CNT_W-1:0] f_total = {1'b0, gap_reg[tig_pkg::TOTAL_LSB +: tig_pkg::FIELD_W]};
  wire logic [tig_pkg::CNT_W-1:0] oh_tbi = TBI_ALT_OVERHEAD ? tig_pkg::OH_TBI_ALT : tig_pkg::OH_TBI;
  wire logic [tig_pkg::CNT_W-1:0] oh_b2b = tbi ? oh_tbi : tig_pkg::OH_TWISTED;
  wire logic [tig_pkg::CNT_W-1:0] len_b2b = f_b2b + oh_b2b;
  wire logic [tig_pkg::CNT_W-1:0] len_total = f_total + tig_pkg::OH_TOTAL;
  // Split gap only in half-duplex and only when not back to back
  wire logic split = half & ~tx_b2b;
  // A carrier drop while idle in half-duplex also opens a split gap
  logic cs_prev_reg;
  wire logic cs_drop = cs_prev_reg & ~cs_reg;
  wire logic start = tx_end | (half & cs_drop & ~tx_b2b);

  // ------------------------------------------------------------
  // Gap state machine
  // ------------------------------------------------------------
  // One count runs through both phases, so the first phase is part of
  // the total rather than added to it
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    target_next = target_reg;
    r1_next = r1_reg;
    case (state_reg)
      tig_pkg::TIG_IDLE: begin
        if (start) begin
          count_next = tig_pkg::CNT_ZERO;
          r1_next = f_first;
          if (split) begin
            target_next = len_total;
            state_next = tig_pkg::TIG_PH1;
          end else begin
            target_next = len_b2b;
            state_next = tig_pkg::TIG_GAP;
          end
        end
      end
      tig_pkg::TIG_PH1: begin
        if (cs_reg) begin
          count_next = tig_pkg::CNT_ZERO;
        end else if (count_reg >= r1_reg) begin
          state_next = tig_pkg::TIG_PH2;
        end else if (tick_reg) begin
          count_next = count_reg + tig_pkg::CNT_ONE;
        end
      end
      tig_pkg::TIG_GAP, tig_pkg::TIG_PH2: begin
        // Carrier no longer looked at here
        if (count_reg >= target_reg) begin
          state_next = tig_pkg::TIG_IDLE;
        end else if (tick_reg) begin
          count_next = count_reg + tig_pkg::CNT_ONE;
        end
      end
      default: begin
        state_next = tig_pkg::TIG_IDLE;
      end
    endcase
  end

  // State, counter and transmit permission
  // Permission follows the next state, so it drops right after the start edge
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= tig_pkg::TIG_IDLE;
      count_reg <= tig_pkg::CNT_ZERO;
      target_reg <= tig_pkg::CNT_ZERO;
      r1_reg <= tig_pkg::CNT_ZERO;
      cs_prev_reg <= 1'b0;
      allow_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      target_reg <= target_next;
      r1_reg <= r1_next;
      cs_prev_reg <= cs_reg;
      allow_reg <= state_next == tig_pkg::TIG_IDLE;
    end
  end

  // Outputs straight from their flops
  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign tx_allow = allow_reg;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  reserved_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (avs_read & wait_reg & sel_gap) |=> (avs_readdata[31:30] == 2'h0))
    else $error("reserved gap bits read nonzero");

  b2b_twisted_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_reg == tig_pkg::TIG_IDLE && start && !split && !tbi)
    |=> (target_reg == $past(f_b2b) + tig_pkg::OH_TWISTED))
    else $error("back-to-back gap lacks twisted overhead");

  b2b_tbi_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_reg == tig_pkg::TIG_IDLE && start && !split && tbi)
    |=> (target_reg == $past(f_b2b) + oh_tbi))
    else $error("back-to-back gap lacks tbi overhead");

  total_len_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_reg == tig_pkg::TIG_IDLE && start && split)
    |=> (target_reg == $past(f_total) + tig_pkg::OH_TOTAL && state_reg == tig_pkg::TIG_PH1))
    else $error("total gap length wrong");

  carrier_restart_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_reg == tig_pkg::TIG_PH1 && cs_reg) |=> (count_reg == tig_pkg::CNT_ZERO))
    else $error("carrier did not restart first phase");

  carrier_ignored_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_reg == tig_pkg::TIG_PH2 && tick_reg && count_reg < target_reg)
    |=> (count_reg == $past(count_reg) + tig_pkg::CNT_ONE))
    else $error("second phase stalled");

  full_duplex_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_reg == tig_pkg::TIG_IDLE && start && !half) |=> (state_reg == tig_pkg::TIG_GAP))
    else $error("phase fields used in full duplex");

  tick_rate_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (tick_reg && speed == tig_pkg::SPEED_100M && $stable(ctrl_reg)) |=> !tick_reg [*8])
    else $error("mac tick too fast");

  hold_tx_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_reg != tig_pkg::TIG_IDLE && state_next != tig_pkg::TIG_IDLE) |=> !tx_allow)
    else $error("transmit allowed during gap");

  gap_start_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_reg == tig_pkg::TIG_IDLE && start) |=> !tx_allow)
    else $error("transmit not held at gap start");

  b2b_plain_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_reg == tig_pkg::TIG_IDLE && start && tx_b2b) |=> (state_reg == tig_pkg::TIG_GAP))
    else $error("back-to-back gap split into phases");

  ph1_exit_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_reg == tig_pkg::TIG_PH1 && !cs_reg && count_reg >= r1_reg) |=> (state_reg == tig_pkg::TIG_PH2))
    else $error("first phase did not end on time");

  gap_end_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_reg == tig_pkg::TIG_GAP && count_reg >= target_reg) |=> tx_allow)
    else $error("transmit still held after gap");

endmodule : tig_gap_timer

/* hw/tig_pkg.sv */
// Constants, register map and state codes of the transmit gap timer.
// Assumes a single 200 MHz system clock and a byte-addressed register bus.
package tig_pkg;

  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam logic [ADDR_W-1:0] ADDR_GAP_TIMING = 16'h0410; // Gap fields
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 16'h0414; // Mode bits
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 16'h0418; // Timer state

  // ------------------------------------------------------------
  // Field layout of the gap register
  // ------------------------------------------------------------
  localparam int FIELD_W = 10;
  localparam int B2B_LSB = 0;
  localparam int FIRST_LSB = 10;
  localparam int TOTAL_LSB = 20;
  localparam int GAP_USED_W = 30; // Bits 31:30 stay zero
  localparam logic [29:0] GAP_RESET = 30'h0000_0000;

  // Control register bits
  localparam int CTRL_HALF_BIT = 0;
  localparam int CTRL_TBI_BIT = 1;
  localparam int CTRL_SPEED_LSB = 2;
  localparam int CTRL_W = 4;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // Status register bits
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_PH1_BIT = 1;
  localparam int STAT_CS_BIT = 2;

  // ------------------------------------------------------------
  // Link speed encoding and MAC clock periods
  // ------------------------------------------------------------
  localparam logic [1:0] SPEED_10M = 2'h0;
  localparam logic [1:0] SPEED_100M = 2'h1;
  localparam logic [1:0] SPEED_1G = 2'h2;
  localparam int CLK_PERIOD_NS = 5;
  localparam int MAC_PERIOD_1G_NS = 8;
  localparam int MAC_PERIOD_100M_NS = 80;
  localparam int MAC_PERIOD_10M_NS = 800;
  localparam int ACC_W = 10;

  // ------------------------------------------------------------
  // Fixed overheads in MAC clocks
  // ------------------------------------------------------------
  localparam int CNT_W = 11;
  localparam logic [CNT_W-1:0] OH_TWISTED = 11'h004;
  localparam logic [CNT_W-1:0] OH_TBI = 11'h00A;
  localparam logic [CNT_W-1:0] OH_TBI_ALT = 11'h006;
  localparam logic [CNT_W-1:0] OH_TOTAL = 11'h006;
  localparam logic [CNT_W-1:0] CNT_ONE = 11'h001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 11'h000;

  // Timer states, one-hot
  typedef enum logic [3:0] {
    TIG_IDLE = 4'h1,
    TIG_GAP = 4'h2,
    TIG_PH1 = 4'h4,
    TIG_PH2 = 4'h8
  } tig_state_t;

endpackage : tig_pkg

/* tb/tig_phy_model.sv */
// Carrier-sense model of the line-side physical layer device.
// Assumes the bench commands each carrier burst on clk_sys; the pin has no pull.
`timescale 1ns/10ps
module tig_phy_model (
  input wire logic clk_sys,
  input wire logic carrier_req,
  output logic carrier_in
);
  // ------------------------------------------------------------
  // Carrier sense
  // ------------------------------------------------------------
  logic carrier_reg = 1'b0; // Starts idle so the pin is never unknown
  // Sense follows the command one cycle late, like a receiver's decode delay
  always_ff @(posedge clk_sys) begin
    carrier_reg <= carrier_req;
  end
  assign carrier_in = carrier_reg;
endmodule : tig_phy_model

/* tb/testbench.sv */
// Self-checking bench of the transmit gap timer, with a carrier model.
// Assumes one 200 MHz clock; gap lengths are checked in ns with tick slack.
`timescale 1ns/10ps
module testbench;
  // ------------------------------------------------------------
  // Signals and counters
  // ------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] avs_address = 16'h0000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic tx_end = 1'b0;
  logic tx_b2b = 1'b0;
  logic carrier_req = 1'b0;
  logic carrier_in;
  logic tx_allow;
  int fail_count = 0;
  int samples_checked = 0;
  logic [31:0] rnd = 32'h0000_126D; // Fixed seed
  logic [31:0] rd;
  int mac_ns [4] = '{800, 80, 8, 800}; // MAC period per speed code
  int f;
  always #2.5 clk_sys = ~clk_sys;
  tig_gap_timer i_tig_gap_timer (.clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .tx_end(tx_end), .tx_b2b(tx_b2b), .carrier_in(carrier_in),
    .tx_allow(tx_allow));
  tig_phy_model i_tig_phy_model (.clk_sys(clk_sys), .carrier_req(carrier_req), .carrier_in(carrier_in));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Xorshift source for field values
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One bus cycle; the request stands until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    // Only the watchdog ends a wait that never sees waitrequest low
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  // Starts a gap and measures how long transmission is held, with carrier bursts
  task automatic run_gap(input logic b2b, input int exp_ns, input int tol, input int c_on, input int c_len);
    int n;
    int low;
    n = 0;
    low = 0;
    @(posedge clk_sys);
    tx_end <= 1'b1;
    tx_b2b <= b2b;
    @(posedge clk_sys);
    tx_end <= 1'b0;
    while (n < 20000 && (low == 0 ? n < 4 : tx_allow !== 1'b1)) begin
      @(posedge clk_sys);
      n++;
      if (tx_allow === 1'b0) low++;
      if (n == c_on) carrier_req <= 1'b1;
      if (n == c_on + c_len) carrier_req <= 1'b0;
    end
    chk(low > 0, 1'b1);
    chk((low * 5 - exp_ns) <= tol && (exp_ns - low * 5) <= tol, 1'b1);
  endtask : run_gap
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  // ------------------------------------------------------------
  // Watchdog: the whole run needs well under 100 us
  // ------------------------------------------------------------
  initial begin
    #100000;
    fail_count++;
    end_sim();
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    // Reset values, unmapped place and reserved bits
    chk(tx_allow, 1'b1);
    bus(1'b0, 16'h0410, 32'h0);
    chk(rd, 32'h0);
    rnd = xs(rnd);
    bus(1'b1, 16'h0410, rnd | 32'hC000_0000);
    bus(1'b1, 16'h041C, 32'hFFFF_FFFF);
    bus(1'b0, 16'h041C, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 16'h0410, 32'h0);
    chk(rd, rnd & 32'h3FFF_FFFF);
    bus(1'b1, 16'h0414, 32'hFFFF_FFF6);
    bus(1'b0, 16'h0414, 32'h0);
    chk(rd, 32'h0000_0006);
    bus(1'b0, 16'h0418, 32'h0);
    chk(rd, 32'h0);
    $display("TEST registers done");
    // Back-to-back gaps for every speed, twisted pair and ten-bit interface
    for (int s = 0; s < 3; s++) begin
      for (int t = 0; t < 2; t++) begin
        rnd = xs(rnd);
        f = (s == 0) ? int'(rnd[1:0]) : int'(rnd[3:0]) + 1;
        bus(1'b1, 16'h0410, {12'h3FF, 10'h3FF, f[9:0]});
        bus(1'b1, 16'h0414, {28'h0, s[1:0], t[0], 1'b0});
        run_gap(1'b1, (f + (t ? 10 : 4)) * mac_ns[s], mac_ns[s] + 20, 0, 0);
      end
    end
    $display("TEST back_to_back done");
    // Phase fields ignored in full duplex and for back-to-back frames
    bus(1'b1, 16'h0410, {2'b00, 10'h006, 10'h008, 10'h00A});
    bus(1'b1, 16'h0414, 32'h0000_0004);
    run_gap(1'b0, 14 * 80, 100, 0, 0);
    bus(1'b1, 16'h0414, 32'h0000_0005);
    run_gap(1'b1, 14 * 80, 100, 0, 0);
    // Half duplex: twelve clocks total, carrier restarts only in phase one
    run_gap(1'b0, 12 * 80, 100, 0, 0);
    run_gap(1'b0, 34 * 5 + 12 * 80, 140, 20, 10);
    run_gap(1'b0, 12 * 80, 100, 160, 10);
    $display("TEST half_duplex done");
    end_sim();
  end
endmodule : testbench
